// ### ampi2c_assertions.sv
// Checker for the two-wire link between the host and the register port
`timescale 1ns/1ns
`include "ampi2c_defs.svh"
module ampi2c_assertions (
    // System
    input wire logic clk,
    input wire logic reset_n,
    // Link
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_h_oe,
    input wire logic sda_t_o,
    input wire logic sda_t_oe,
    // Straps
    input wire logic addr_select_low_pin,
    input wire logic addr_select_high_pin
);
    logic scl_q_ff, sda_q_ff, mute_ff, rise, strt, match;
    logic [5:0] cnt_ff;
    logic [7:0] adr_ff;
    logic [8:0] per_ff;
    assign rise = scl && !scl_q_ff;
    assign strt = scl && scl_q_ff && sda_q_ff && !sda;
    assign match = adr_ff[7:1] == {`AMPI2C_PIN_ADDR_HI, addr_select_high_pin,
        addr_select_low_pin} || adr_ff[7:1] == `AMPI2C_GEN_ADDR;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ************************************************************
    // Link decode
    // ************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            scl_q_ff <= scl;
            sda_q_ff <= sda;
        end
    end
    // Rises since the last start; saturates so idle time cannot wrap
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) cnt_ff <= 6'h3f;
        else if (strt) cnt_ff <= 6'h00;
        else if (rise && cnt_ff != 6'h3f) cnt_ff <= cnt_ff + 6'h01;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) adr_ff <= 8'h00;
        else if (rise && cnt_ff < 6'h08) adr_ff <= {adr_ff[6:0], sda};
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) per_ff <= 9'h1ff;
        else if (rise) per_ff <= 9'h000;
        else if (per_ff != 9'h1ff) per_ff <= per_ff + 9'h001;
    end
    // Set by an unmatched address or a nack of the second read byte, cleared by a start
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) mute_ff <= 1'b0;
        else if (strt) mute_ff <= 1'b0;
        else if (rise && cnt_ff == 6'h08 && !match) mute_ff <= 1'b1;
        else if (rise && cnt_ff == 6'h1a && adr_ff[0] && sda) mute_ff <= 1'b1;
    end
    // ************************************************************
    // Properties
    // ************************************************************
    chk_tgt_edge_low: assert property (scl && scl_q_ff |-> $stable(sda_t_oe))
        else $error("target changed data while clock high");
    chk_open_drain: assert property (sda_t_oe |-> !sda_t_o)
        else $error("target drove the data line high");
    chk_no_contention: assert property (scl |-> !(sda_h_oe && sda_t_oe))
        else $error("both ends drive the data line");
    chk_scl_rate: assert property (rise && cnt_ff != 6'h00 && cnt_ff < 6'h08
        |-> per_ff >= 9'h0f9)
        else $error("bit period shorter than fast mode allows");
    chk_addr_ack: assert property (rise && cnt_ff == 6'h08 && match |-> !sda)
        else $error("matching address not acknowledged");
    chk_addr_nack: assert property (rise && cnt_ff == 6'h08 && !match |-> sda)
        else $error("foreign address acknowledged");
    chk_wr_ack: assert property (rise && cnt_ff > 6'h08 && !adr_ff[0] && match
        && cnt_ff % 6'h09 == 6'h08 |-> !sda)
        else $error("written byte not acknowledged");
    chk_rd_release: assert property (rise && cnt_ff > 6'h08 && adr_ff[0]
        && match && cnt_ff % 6'h09 == 6'h08 |-> !sda_t_oe)
        else $error("target holds the line in the host ack slot");
    chk_quiet_after: assert property (mute_ff |-> !sda_t_oe)
        else $error("target drives after nack or foreign address");
endmodule

// ### ampi2c_defs.svh
// Constants for the amplifier I2C register port
`ifndef AMPI2C_DEFS_SVH
`define AMPI2C_DEFS_SVH

`define AMPI2C_PIN_ADDR_HI 5'h0d
`define AMPI2C_GEN_ADDR 7'h0e
`define AMPI2C_PTR_RESET 8'h00
`define AMPI2C_SCL_HZ 400000
`define AMPI2C_CLK_HZ 100000000
// Quarter SCL period in clk cycles, rounded up so SCL never beats fast mode
`define AMPI2C_QTR_CYC (((`AMPI2C_CLK_HZ / `AMPI2C_SCL_HZ) + 3) / 4)

`endif

// ### ampi2c_host.sv
// Host end: issues register write and read transfers on the link
`timescale 1ns/1ns
`include "ampi2c_defs.svh"
module ampi2c_host
    import ampi2c_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic reset_n,
    // Link
    ampi2c_if.host bus,
    // Command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic [6:0] cmd_addr,
    input wire logic [7:0] cmd_ptr,
    input wire logic [15:0] cmd_wdata,
    // Result
    output logic rsp_valid_ff,
    output logic rsp_nack_ff,
    output logic [15:0] rsp_rdata_ff
);
    localparam int QTR = `AMPI2C_QTR_CYC;
    ampi2c_host_state_t state_ff;
    logic [7:0] qcnt_ff;
    logic [1:0] phase_ff;
    logic [2:0] bit_ff;
    logic [2:0] byte_ff;
    logic [7:0] tx_ff;
    logic [7:0] rx_ff;
    logic rd_ff, rs_done_ff;
    logic [6:0] addr_ff;
    logic [7:0] ptr_ff;
    logic [15:0] wd_ff;
    logic sda_s1_ff, sda_s2_ff;
    logic tick;

    // Line level returns from the wire: two flops before use
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
        end else begin
            sda_s1_ff <= bus.sda;
            sda_s2_ff <= sda_s1_ff;
        end
    end

    assign tick = qcnt_ff == 8'(QTR - 1);
    assign cmd_ready = state_ff == AMPI2C_H_IDLE;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            qcnt_ff <= 8'h00;
        end else if (tick || state_ff == AMPI2C_H_IDLE) begin
            qcnt_ff <= 8'h00;
        end else begin
            qcnt_ff <= qcnt_ff + 8'h01;
        end
    end

    // ****************************************************************
    // Sequencer: bytes 0 addr/w, 1 ptr, 2 hi, 3 lo; read: 2 addr/r, 3..4 data
    // ****************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= AMPI2C_H_IDLE;
            phase_ff <= 2'h0;
            bit_ff <= 3'h7;
            byte_ff <= 3'h0;
            tx_ff <= 8'h00;
            rx_ff <= 8'h00;
            rd_ff <= 1'b0;
            rs_done_ff <= 1'b0;
            addr_ff <= 7'h00;
            ptr_ff <= 8'h00;
            wd_ff <= 16'h0000;
            bus.scl <= 1'b1;
            bus.sda_h_oe <= 1'b0;
            rsp_valid_ff <= 1'b0;
            rsp_nack_ff <= 1'b0;
            rsp_rdata_ff <= 16'h0000;
        end else begin
            rsp_valid_ff <= 1'b0;
            unique case (state_ff)
                AMPI2C_H_IDLE: begin
                    if (cmd_valid) begin
                        rd_ff <= cmd_read;
                        addr_ff <= cmd_addr;
                        ptr_ff <= cmd_ptr;
                        wd_ff <= cmd_wdata;
                        tx_ff <= {cmd_addr, 1'b0};
                        byte_ff <= 3'h0;
                        rs_done_ff <= 1'b0;
                        rsp_nack_ff <= 1'b0;
                        phase_ff <= 2'h0;
                        state_ff <= AMPI2C_H_START;
                    end
                end
                AMPI2C_H_START, AMPI2C_H_RSTART: if (tick) begin
                    phase_ff <= phase_ff + 2'h1;
                    unique case (phase_ff)
                        2'h0: bus.sda_h_oe <= 1'b0;
                        2'h1: bus.scl <= 1'b1;
                        2'h2: bus.sda_h_oe <= 1'b1;
                        default: begin
                            bus.scl <= 1'b0;
                            bit_ff <= 3'h7;
                            state_ff <= AMPI2C_H_BIT;
                        end
                    endcase
                end
                AMPI2C_H_BIT, AMPI2C_H_ACK: if (tick) begin
                    phase_ff <= phase_ff + 2'h1;
                    unique case (phase_ff)
                        2'h0: begin
                            if (state_ff == AMPI2C_H_ACK) begin
                                // Ack high byte, nack final low byte
                                bus.sda_h_oe <= rd_ff && rs_done_ff
                                    && byte_ff == 3'h3;
                            end else begin
                                bus.sda_h_oe <= !(rd_ff && rs_done_ff
                                    && byte_ff >= 3'h3) && !tx_ff[bit_ff];
                            end
                        end
                        2'h1: bus.scl <= 1'b1;
                        2'h2: begin
                            if (state_ff == AMPI2C_H_BIT) begin
                                rx_ff <= {rx_ff[6:0], sda_s2_ff};
                            end else if (sda_s2_ff && !(rd_ff && rs_done_ff
                                         && byte_ff >= 3'h3)) begin
                                rsp_nack_ff <= 1'b1;
                            end
                        end
                        default: begin
                            bus.scl <= 1'b0;
                            if (state_ff == AMPI2C_H_BIT) begin
                                bit_ff <= bit_ff - 3'h1;
                                if (bit_ff == 3'h0) begin
                                    state_ff <= AMPI2C_H_ACK;
                                end
                            end else begin
                                if (rd_ff && byte_ff == 3'h3) begin
                                    rsp_rdata_ff[15:8] <= rx_ff;
                                end
                                if (rd_ff && byte_ff == 3'h4) begin
                                    rsp_rdata_ff[7:0] <= rx_ff;
                                end
                                byte_ff <= byte_ff + 3'h1;
                                bit_ff <= 3'h7;
                                state_ff <= AMPI2C_H_BIT;
                                if (rsp_nack_ff || (!rd_ff && byte_ff == 3'h3)
                                    || (rd_ff && byte_ff == 3'h4)) begin
                                    state_ff <= AMPI2C_H_STOP;
                                end else if (rd_ff && byte_ff == 3'h1) begin
                                    tx_ff <= {addr_ff, 1'b1};
                                    rs_done_ff <= 1'b1;
                                    state_ff <= AMPI2C_H_RSTART;
                                end else if (byte_ff == 3'h0) begin
                                    tx_ff <= ptr_ff;
                                end else if (byte_ff == 3'h1) begin
                                    tx_ff <= wd_ff[15:8];
                                end else begin
                                    tx_ff <= wd_ff[7:0];
                                end
                            end
                        end
                    endcase
                end
                AMPI2C_H_STOP: if (tick) begin
                    phase_ff <= phase_ff + 2'h1;
                    unique case (phase_ff)
                        2'h0: bus.sda_h_oe <= 1'b1;
                        2'h1: bus.scl <= 1'b1;
                        2'h2: bus.sda_h_oe <= 1'b0;
                        default: state_ff <= AMPI2C_H_DONE;
                    endcase
                end
                default: begin
                    rsp_valid_ff <= 1'b1;
                    state_ff <= AMPI2C_H_IDLE;
                end
            endcase
        end
    end
    assign bus.sda_h_o = 1'b0;
endmodule

// ### ampi2c_if.sv
// Two-wire bus joining the host and the amplifier register port
`timescale 1ns/1ns
interface ampi2c_if;
    // Host side drives
    logic scl;
    logic sda_h_o;
    logic sda_h_oe;
    // Target side drives
    logic sda_t_o;
    logic sda_t_oe;
    // Resolved open-drain line level, pulled up when nobody drives low
    logic sda;
    assign sda = !((sda_h_oe && !sda_h_o) || (sda_t_oe && !sda_t_o));

    modport host (output scl, output sda_h_o, output sda_h_oe, input sda);
    modport target (input scl, output sda_t_o, output sda_t_oe, input sda);
endinterface

// ### ampi2c_pkg.sv
// Types shared by both ends of the amplifier I2C register port
package ampi2c_pkg;
    typedef enum logic [2:0] {
        AMPI2C_T_IDLE,
        AMPI2C_T_ADDR,
        AMPI2C_T_PTR,
        AMPI2C_T_WDATA,
        AMPI2C_T_RDATA,
        AMPI2C_T_IGNORE
    } ampi2c_tgt_state_t;

    typedef enum logic [3:0] {
        AMPI2C_H_IDLE,
        AMPI2C_H_START,
        AMPI2C_H_BIT,
        AMPI2C_H_ACK,
        AMPI2C_H_RSTART,
        AMPI2C_H_STOP,
        AMPI2C_H_DONE
    } ampi2c_host_state_t;
endpackage

// ### ampi2c_target.sv
// Amplifier I2C target: register pointer, byte pairs, address match
`timescale 1ns/1ns
`include "ampi2c_defs.svh"
module ampi2c_target
    import ampi2c_pkg::*;
(
    // Link, clocked by the bus clock
    ampi2c_if.target bus,
    input wire logic reset_n,
    // Address select straps
    input wire logic addr_select_low_pin,
    input wire logic addr_select_high_pin,
    // Register file access, on the bus clock
    output logic wr_en_ff,
    output logic [7:0] wr_ptr_ff,
    output logic [15:0] wr_data_ff,
    output logic [7:0] rd_ptr,
    input wire logic [15:0] rd_data
);
    // ****************************************************************
    // Start and stop detection
    // ****************************************************************
    // SDA edges while SCL high; start/stop flags clear on the next SCL fall
    logic start_tog_ff, stop_tog_ff, start_seen_ff, stop_seen_ff;
    logic ss_rst_n;
    assign ss_rst_n = reset_n;
    always_ff @(negedge bus.sda or negedge ss_rst_n) begin
        if (!ss_rst_n) begin
            start_tog_ff <= 1'b0;
        end else if (bus.scl) begin
            start_tog_ff <= !start_tog_ff;
        end
    end
    always_ff @(posedge bus.sda or negedge ss_rst_n) begin
        if (!ss_rst_n) begin
            stop_tog_ff <= 1'b0;
        end else if (bus.scl) begin
            stop_tog_ff <= !stop_tog_ff;
        end
    end
    // Toggles seen on SCL fall; a start is always followed by one
    // Pending flags carry the event to the next SCL rise, as the seen
    // flags are already cleared by then
    logic start_ack_ff, stop_ack_ff, start_pend_ff, stop_pend_ff;
    always_ff @(negedge bus.scl or negedge reset_n) begin
        if (!reset_n) begin
            start_ack_ff <= 1'b0;
            stop_ack_ff <= 1'b0;
            start_pend_ff <= 1'b0;
            stop_pend_ff <= 1'b0;
        end else begin
            start_ack_ff <= start_tog_ff;
            stop_ack_ff <= stop_tog_ff;
            start_pend_ff <= start_seen_ff;
            stop_pend_ff <= stop_seen_ff;
        end
    end
    // Straps come from pins: two flops on the bus clock
    logic [1:0] sel_s1_ff, sel_s2_ff;
    always_ff @(posedge bus.scl or negedge reset_n) begin
        if (!reset_n) begin
            sel_s1_ff <= 2'h0;
            sel_s2_ff <= 2'h0;
        end else begin
            sel_s1_ff <= {addr_select_high_pin, addr_select_low_pin};
            sel_s2_ff <= sel_s1_ff;
        end
    end
    assign start_seen_ff = start_tog_ff != start_ack_ff;
    assign stop_seen_ff = stop_tog_ff != stop_ack_ff;

    // ****************************************************************
    // Receive shifter and byte framing
    // ****************************************************************
    ampi2c_tgt_state_t state_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] ptr_ff;
    logic [7:0] hi_byte_ff;
    logic half_ff;
    logic rd_ok_ff;
    logic [7:0] tx_ff;
    logic ack_slot;
    logic [7:0] rx_byte;
    logic [6:0] pin_addr;
    logic addr_match;

    assign pin_addr = {`AMPI2C_PIN_ADDR_HI, sel_s2_ff};
    assign rx_byte = {shift_ff[6:0], bus.sda};
    assign addr_match = rx_byte[7:1] == pin_addr
        || rx_byte[7:1] == `AMPI2C_GEN_ADDR;
    assign ack_slot = bit_cnt_ff == 4'd8;
    assign rd_ptr = ptr_ff;

    // Sample SDA on SCL rise; bit 8 is the acknowledge slot
    always_ff @(posedge bus.scl or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= AMPI2C_T_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            ptr_ff <= `AMPI2C_PTR_RESET;
            hi_byte_ff <= 8'h00;
            half_ff <= 1'b0;
            rd_ok_ff <= 1'b0;
            wr_en_ff <= 1'b0;
            wr_ptr_ff <= 8'h00;
            wr_data_ff <= 16'h0000;
        end else begin
            wr_en_ff <= 1'b0;
            if (start_pend_ff) begin
                // Abort any half pair and frame a new address byte
                state_ff <= AMPI2C_T_ADDR;
                half_ff <= 1'b0;
                bit_cnt_ff <= 4'h1;
                shift_ff <= {7'h00, bus.sda};
            end else if (stop_pend_ff) begin
                state_ff <= AMPI2C_T_IDLE;
                half_ff <= 1'b0;
            end else if (ack_slot) begin
                bit_cnt_ff <= 4'h0;
                rd_ok_ff <= 1'b0;
                if (rd_ok_ff) begin
                    // Own ack of the read address, not a host answer
                    half_ff <= 1'b0;
                end else if (state_ff == AMPI2C_T_RDATA && bus.sda) begin
                    state_ff <= AMPI2C_T_IGNORE;
                end else if (state_ff == AMPI2C_T_RDATA && half_ff) begin
                    half_ff <= 1'b0;
                    ptr_ff <= ptr_ff + 8'h01;
                end else if (state_ff == AMPI2C_T_RDATA) begin
                    half_ff <= 1'b1;
                end
            end else if (state_ff != AMPI2C_T_IDLE
                         && state_ff != AMPI2C_T_IGNORE) begin
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
                shift_ff <= rx_byte;
                if (bit_cnt_ff == 4'd7) begin
                    unique case (state_ff)
                        AMPI2C_T_ADDR: begin
                            if (!addr_match) begin
                                state_ff <= AMPI2C_T_IGNORE;
                            end else if (rx_byte[0]) begin
                                state_ff <= AMPI2C_T_RDATA;
                                half_ff <= 1'b0;
                            end else begin
                                state_ff <= AMPI2C_T_PTR;
                            end
                            rd_ok_ff <= addr_match && rx_byte[0];
                        end
                        AMPI2C_T_PTR: begin
                            ptr_ff <= rx_byte;
                            half_ff <= 1'b0;
                            state_ff <= AMPI2C_T_WDATA;
                        end
                        AMPI2C_T_WDATA: begin
                            if (half_ff) begin
                                wr_en_ff <= 1'b1;
                                wr_ptr_ff <= ptr_ff;
                                wr_data_ff <= {hi_byte_ff, rx_byte};
                                ptr_ff <= ptr_ff + 8'h01;
                            end else begin
                                hi_byte_ff <= rx_byte;
                            end
                            half_ff <= !half_ff;
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // ****************************************************************
    // SDA drive, changed on SCL fall only
    // ****************************************************************
    // Byte to send is loaded on the fall that ends the ack slot, as its first bit goes out
    logic drive_low_ff;
    logic [2:0] tx_idx_ff;
    always_ff @(negedge bus.scl or negedge reset_n) begin
        if (!reset_n) begin
            drive_low_ff <= 1'b0;
            tx_ff <= 8'h00;
            tx_idx_ff <= 3'h7;
        end else if (start_seen_ff || stop_seen_ff) begin
            drive_low_ff <= 1'b0;
            tx_idx_ff <= 3'h7;
        end else if (ack_slot && (rd_ok_ff
                     || (state_ff != AMPI2C_T_RDATA
                     && state_ff != AMPI2C_T_IGNORE
                     && state_ff != AMPI2C_T_IDLE))) begin
            // Falling edge opening the ack slot of a received byte
            drive_low_ff <= 1'b1;
        end else if (state_ff == AMPI2C_T_RDATA && bit_cnt_ff <= 4'd7) begin
            // First bit takes the fresh byte, later bits shift out
            drive_low_ff <= bit_cnt_ff == 4'd0
                ? !(half_ff ? rd_data[7] : rd_data[15])
                : !tx_ff[tx_idx_ff];
            if (bit_cnt_ff == 4'd0) begin
                tx_ff <= half_ff ? rd_data[7:0] : rd_data[15:8];
                tx_idx_ff <= 3'h6;
            end else begin
                tx_idx_ff <= tx_idx_ff - 3'h1;
            end
        end else if (state_ff == AMPI2C_T_RDATA && ack_slot) begin
            drive_low_ff <= 1'b0;
        end else begin
            drive_low_ff <= 1'b0;
        end
    end
    assign bus.sda_t_o = 1'b0;
    assign bus.sda_t_oe = drive_low_ff && state_ff != AMPI2C_T_IGNORE
        && state_ff != AMPI2C_T_IDLE;
endmodule

// ### tb.sv
// Self-checking bench for the amplifier I2C register port
`timescale 1ns/1ns
`include "ampi2c_defs.svh"
module tb;
    import ampi2c_pkg::*;
    logic clk, reset_n, cmd_valid, cmd_read, cmd_ready, sel_lo, sel_hi;
    logic rsp_valid_ff, rsp_nack_ff, wr_en, wr_en_b, s;
    logic [6:0] cmd_addr;
    logic [7:0] cmd_ptr, wr_ptr, rd_ptr, wr_ptr_b, rd_ptr_b, d;
    logic [15:0] cmd_wdata, rsp_rdata_ff, wr_data, wr_data_b, w;
    logic [15:0] regs [256];
    logic [15:0] regs_b [256];
    logic [7:0] wr_seq [6] = '{8'h1c, 8'h10, 8'h13, 8'h57, 8'h24, 8'h68};
    logic [7:0] ab_seq [3] = '{8'h1c, 8'h20, 8'h99};
    int error_cnt, num_checks;
    ampi2c_if bus ();
    ampi2c_if bus_b ();
    ampi2c_host ampi2c_host_inst (.clk(clk), .reset_n(reset_n), .bus(bus),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
        .cmd_addr(cmd_addr), .cmd_ptr(cmd_ptr), .cmd_wdata(cmd_wdata),
        .rsp_valid_ff(rsp_valid_ff), .rsp_nack_ff(rsp_nack_ff),
        .rsp_rdata_ff(rsp_rdata_ff));
    ampi2c_target ampi2c_target_inst (.bus(bus), .reset_n(reset_n),
        .addr_select_low_pin(sel_lo), .addr_select_high_pin(sel_hi),
        .wr_en_ff(wr_en), .wr_ptr_ff(wr_ptr), .wr_data_ff(wr_data),
        .rd_ptr(rd_ptr), .rd_data(regs[rd_ptr]));
    // Second port is driven bit by bit to break the host's usual order
    ampi2c_target ampi2c_target_b_inst (.bus(bus_b), .reset_n(reset_n),
        .addr_select_low_pin(1'b0), .addr_select_high_pin(1'b0),
        .wr_en_ff(wr_en_b), .wr_ptr_ff(wr_ptr_b), .wr_data_ff(wr_data_b),
        .rd_ptr(rd_ptr_b), .rd_data(regs_b[rd_ptr_b]));
    ampi2c_assertions ampi2c_assertions_inst (.clk(clk), .reset_n(reset_n),
        .scl(bus.scl), .sda(bus.sda), .sda_h_oe(bus.sda_h_oe),
        .sda_t_o(bus.sda_t_o), .sda_t_oe(bus.sda_t_oe),
        .addr_select_low_pin(sel_lo), .addr_select_high_pin(sel_hi));
    always @(posedge bus.scl) if (wr_en === 1'b1) regs[wr_ptr] <= wr_data;
    always @(posedge bus_b.scl) begin
        if (wr_en_b === 1'b1) regs_b[wr_ptr_b] <= wr_data_b;
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic timeout;
        error_cnt++;
        $display("[FAIL] %0t exp %h got %h", $time, 1'b1, 1'b0);
        end_sim();
    endtask
    task automatic check16(input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic check1(input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic host_xfer(input logic rd, input logic [6:0] a,
        input logic [7:0] p, input logic [15:0] v);
        int n;
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd_read = rd;
        cmd_addr = a;
        cmd_ptr = p;
        cmd_wdata = v;
        for (n = 0; cmd_ready !== 1'b1; n++) begin
            if (n == 1000) timeout();
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        for (n = 0; rsp_valid_ff !== 1'b1; n++) begin
            if (n == 30000) timeout();
            @(posedge clk);
            #1;
        end
    endtask
    // One 64 ns bit; data moves only while the clock is low
    task automatic bb_bit(input logic b, output logic got);
        bus_b.sda_h_oe = !b;
        #16 bus_b.scl = 1'b1;
        #16 got = bus_b.sda;
        #16 bus_b.scl = 1'b0;
        #16;
    endtask
    task automatic bb_start;
        bus_b.sda_h_oe = 1'b0;
        #16 bus_b.scl = 1'b1;
        #16 bus_b.sda_h_oe = 1'b1;
        #16 bus_b.scl = 1'b0;
        #16;
    endtask
    task automatic bb_stop;
        bus_b.sda_h_oe = 1'b1;
        #16 bus_b.scl = 1'b1;
        #16 bus_b.sda_h_oe = 1'b0;
        #32;
    endtask
    task automatic bb_put(input logic [7:0] b, input logic exp);
        logic a;
        for (int i = 7; i >= 0; i--) bb_bit(b[i], a);
        bb_bit(1'b1, a);
        check1(exp, a);
    endtask
    task automatic bb_rd(input logic na, output logic [7:0] q);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bb_bit(1'b1, b);
            q[i] = b;
        end
        bb_bit(na, b);
    endtask
    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        reset_n = 1'b0;
        {cmd_valid, cmd_read, sel_lo, sel_hi} = 4'h0;
        {cmd_addr, cmd_ptr, cmd_wdata} = 31'h0;
        {bus_b.scl, bus_b.sda_h_o, bus_b.sda_h_oe} = 3'h4;
        {error_cnt, num_checks, w} = 0;
        for (int i = 0; i < 256; i++) begin
            regs[i] = {8'h00, i[7:0]};
            regs_b[i] = {8'hff, i[7:0]};
        end
        repeat (5) @(posedge clk);
        #1;
        reset_n = 1'b1;
        for (int k = 0; k < 4; k++) begin
            {sel_hi, sel_lo} = k[1:0];
            host_xfer(1'b0, {`AMPI2C_PIN_ADDR_HI, k[1:0]}, 8'h40 + k[7:0],
                16'ha5c0 + k[15:0]);
            check1(1'b0, rsp_nack_ff);
            check16(16'ha5c0 + k[15:0], regs[8'h40 + k[7:0]]);
        end
        host_xfer(1'b1, `AMPI2C_GEN_ADDR, 8'h42, 16'h0000);
        check1(1'b0, rsp_nack_ff);
        check16(16'ha5c2, rsp_rdata_ff);
        {sel_hi, sel_lo} = 2'b00;
        host_xfer(1'b0, 7'h35, 8'h41, 16'h1234);
        check1(1'b1, rsp_nack_ff);
        check16(16'ha5c1, regs[8'h41]);
        bb_start();
        foreach (wr_seq[i]) bb_put(wr_seq[i], 1'b0);
        bb_stop();
        check16(16'h1357, regs_b[8'h10]);
        check16(16'h2468, regs_b[8'h11]);
        bb_start();
        foreach (ab_seq[i]) bb_put(ab_seq[i], 1'b0);
        bb_bit(1'b1, s);
        bb_bit(1'b0, s);
        bb_start();
        bb_stop();
        check16(16'hff20, regs_b[8'h20]);
        bb_start();
        bb_put(8'h1c, 1'b0);
        bb_put(8'h10, 1'b0);
        bb_start();
        bb_put(8'h1d, 1'b0);
        for (int i = 0; i < 4; i++) begin
            bb_rd(i == 3, d);
            w = {w[7:0], d};
            if (i[0]) check16(i < 2 ? 16'h1357 : 16'h2468, w);
        end
        bb_bit(1'b1, s);
        check1(1'b1, s);
        bb_stop();
        bb_start();
        bb_put(8'h50, 1'b1);
        bb_put(8'h00, 1'b1);
        bb_stop();
        end_sim();
    end
endmodule
